// *** pq_event_pkg.sv ***
// Behaviour
// - writable 24-bit dip threshold, resets to zero
// - writable 24-bit swell threshold, resets all ones
// - per-phase dip rms capture, resets 0x7FFFFF
// - per-phase swell rms capture, resets zero
// - phase A no-load flags in bits 0-5
// - phase B no-load flags in bits 6-11
// - phase C bits 12-17, upper bits read zero
// - dip/swell enables drive active-low event pin
// - no-load enables 10-13 pull event pin low
`default_nettype none
package pq_event_pkg;
   // register indices; byte address is four times the index
   localparam logic [11:0] IDX_DIP_THR = 12'h410;
   localparam logic [11:0] IDX_DIP_A = 12'h411;
   localparam logic [11:0] IDX_DIP_B = 12'h412;
   localparam logic [11:0] IDX_DIP_C = 12'h413;
   localparam logic [11:0] IDX_SWELL_THR = 12'h414;
   localparam logic [11:0] IDX_SWELL_A = 12'h415;
   localparam logic [11:0] IDX_SWELL_B = 12'h416;
   localparam logic [11:0] IDX_SWELL_C = 12'h417;
   localparam logic [11:0] IDX_NOLOAD = 12'h41F;
   localparam logic [11:0] IDX_EVT_EN = 12'h480;
   localparam logic [11:0] IDX_IRQ_STAT = 12'h481;
   localparam logic [11:0] IDX_IRQ_MASK = 12'h482;
   // reset values
   localparam logic [23:0] RST_DIP_THR = 24'h000000;
   localparam logic [23:0] RST_SWELL_THR = 24'hFFFFFF;
   localparam logic [23:0] RST_DIP_VAL = 24'h7FFFFF;
   localparam logic [23:0] RST_SWELL_VAL = 24'h000000;
   localparam logic [13:0] RST_EVT_EN = 14'h0000;
   localparam logic [6:0] RST_IRQ = 7'h00;
   // event enable field positions
   localparam int EN_DIP_LSB = 0;
   localparam int EN_SWELL_LSB = 3;
   localparam int EN_TOT_ACT = 10;
   localparam int EN_TOT_REACT = 11;
   localparam int EN_TOT_APP = 12;
   localparam int EN_FUND_ACT = 13;
   // interrupt status field positions
   localparam int IRQ_DIP_LSB = 0;
   localparam int IRQ_SWELL_LSB = 3;
   localparam int IRQ_NOLOAD = 6;
   // widths
   localparam int VAL_W = 24;
   localparam int EN_W = 14;
   localparam int IRQ_W = 7;
   localparam int NL_W = 18;

   // one phase of no-load flags, msb first in the status word
   typedef struct packed {
      logic fund_apparent;
      logic fund_reactive;
      logic fund_active;
      logic total_apparent;
      logic total_reactive;
      logic total_active;
   } phase_noload_t;

   // no-load flags of all phases, phase A in the low bits
   typedef struct packed {
      phase_noload_t pc;
      phase_noload_t pb;
      phase_noload_t pa;
   } noload_t;

   // half-cycle rms voltages with their update strobe
   typedef struct packed {
      logic valid;
      logic [23:0] a;
      logic [23:0] b;
      logic [23:0] c;
   } rms_sample_t;

   // captured ahb address phase
   typedef struct packed {
      logic wr;
      logic [11:0] idx;
   } ahb_addr_t;
endpackage
`default_nettype wire

// *** pq_event_regs.sv ***
// The AHB-Lite register port is this design's own decision.
`timescale 1ns/1ns
`default_nettype none
module pq_event_regs (
   // clock and reset
   input wire logic I_CLK,
   input wire logic I_RESETN,
   // ahb-lite slave
   input wire logic I_HSEL,
   input wire logic [31:0] I_HADDR,
   input wire logic [1:0] I_HTRANS,
   input wire logic I_HWRITE,
   input wire logic [2:0] I_HSIZE,
   input wire logic [31:0] I_HWDATA,
   input wire logic I_HREADY,
   output logic [31:0] O_HRDATA,
   output logic O_HREADYOUT,
   output logic O_HRESP,
   // metering inputs
   input wire pq_event_pkg::rms_sample_t I_RMS,
   input wire pq_event_pkg::noload_t I_NOLOAD,
   // event and interrupt outputs
   output logic O_EVENT_N,
   output logic O_IRQ
);
   import pq_event_pkg::*;

   logic [VAL_W-1:0] dip_thr_reg;
   logic [VAL_W-1:0] swell_thr_reg;
   logic [VAL_W-1:0] dip_val_reg [3];
   logic [VAL_W-1:0] swell_val_reg [3];
   logic [2:0] dip_act_reg;
   logic [2:0] swell_act_reg;
   logic [NL_W-1:0] noload_reg;
   logic [EN_W-1:0] evt_en_reg;
   logic [IRQ_W-1:0] irq_stat_reg;
   logic [IRQ_W-1:0] irq_mask_reg;
   logic [IRQ_W-1:0] irq_set;
   logic [IRQ_W-1:0] irq_clr;
   ahb_addr_t dph_reg;
   logic wr_pend_reg;
   logic [31:0] rdata_reg;
   logic event_n_reg;
   logic irq_reg;
   logic addr_ok;
   logic [11:0] addr_idx;
   logic req;
   logic rd_req;
   logic [31:0] rd_val;
   logic [VAL_W-1:0] rms_v [3];
   logic [2:0] dip_hit;
   logic [2:0] swell_hit;
   logic [NL_W-1:0] noload_now;
   logic any_tot_act;
   logic any_tot_react;
   logic any_tot_app;
   logic any_fund_act;
   logic evt_low;

   // widen a 24-bit field into a bus word, upper bits zero
   function automatic logic [31:0] word24(input logic [VAL_W-1:0] v);
      return {8'h00, v};
   endfunction

   // merge a pending write into a read of the same register
   function automatic logic [31:0] fwd(input logic [31:0] cur,
                                       input logic [31:0] wdat,
                                       input logic [31:0] fmask,
                                       input logic hit);
      return hit ? (wdat & fmask) : cur;
   endfunction

   // address decode: word aligned, upper bits zero
   assign addr_idx = I_HADDR[13:2];
   assign addr_ok = (I_HADDR[31:14] == 18'h00000) && (I_HADDR[1:0] == 2'h0);
   assign req = I_HSEL && I_HREADY && I_HTRANS[1];
   assign rd_req = req && !I_HWRITE;

   // zero wait states, always okay
   assign O_HREADYOUT = 1'b1;
   assign O_HRESP = 1'b0;
   assign O_HRDATA = rdata_reg;
   assign O_EVENT_N = event_n_reg;
   assign O_IRQ = irq_reg;

   // rms per phase in an indexable form
   assign rms_v[0] = I_RMS.a;
   assign rms_v[1] = I_RMS.b;
   assign rms_v[2] = I_RMS.c;

   // threshold compares for each phase
   always_comb begin
      for (int p = 0; p < 3; p++) begin
         dip_hit[p] = rms_v[p] < dip_thr_reg;
         swell_hit[p] = rms_v[p] > swell_thr_reg;
      end
   end

   // no-load word layout by phase, c total reactive lands on bit 13
   assign noload_now = {I_NOLOAD.pc,
                        I_NOLOAD.pb,
                        I_NOLOAD.pa};

   // address phase capture for the following data phase
   always_ff @(posedge I_CLK or negedge I_RESETN) begin
      if (!I_RESETN) begin
         dph_reg <= '0;
         wr_pend_reg <= 1'b0;
      end else if (I_HREADY) begin
         wr_pend_reg <= req && I_HWRITE && addr_ok;
         dph_reg.wr <= I_HWRITE;
         dph_reg.idx <= addr_idx;
      end
   end

   // threshold registers, written in the data phase
   always_ff @(posedge I_CLK or negedge I_RESETN) begin
      if (!I_RESETN) begin
         dip_thr_reg <= RST_DIP_THR;
         swell_thr_reg <= RST_SWELL_THR;
      end else if (wr_pend_reg && dph_reg.wr) begin
         if (dph_reg.idx == IDX_DIP_THR) begin
            dip_thr_reg <= I_HWDATA[VAL_W-1:0];
         end
         if (dph_reg.idx == IDX_SWELL_THR) begin
            swell_thr_reg <= I_HWDATA[VAL_W-1:0];
         end
      end
   end

   // event enable and interrupt mask registers
   always_ff @(posedge I_CLK or negedge I_RESETN) begin
      if (!I_RESETN) begin
         evt_en_reg <= RST_EVT_EN;
         irq_mask_reg <= RST_IRQ;
      end else if (wr_pend_reg && dph_reg.wr) begin
         if (dph_reg.idx == IDX_EVT_EN) begin
            evt_en_reg <= I_HWDATA[EN_W-1:0];
         end
         if (dph_reg.idx == IDX_IRQ_MASK) begin
            irq_mask_reg <= I_HWDATA[IRQ_W-1:0];
         end
      end
   end

   // per-phase dip and swell state, updated on each half-cycle value
   always_ff @(posedge I_CLK or negedge I_RESETN) begin
      if (!I_RESETN) begin
         dip_act_reg <= 3'h0;
         swell_act_reg <= 3'h0;
      end else if (I_RMS.valid) begin
         dip_act_reg <= dip_hit;
         swell_act_reg <= swell_hit;
      end
   end

   // capture the rms value while a phase is in dip or swell
   always_ff @(posedge I_CLK or negedge I_RESETN) begin
      if (!I_RESETN) begin
         for (int p = 0; p < 3; p++) begin
            dip_val_reg[p] <= RST_DIP_VAL;
            swell_val_reg[p] <= RST_SWELL_VAL;
         end
      end else if (I_RMS.valid) begin
         for (int p = 0; p < 3; p++) begin
            if (dip_hit[p]) begin
               dip_val_reg[p] <= rms_v[p];
            end
            if (swell_hit[p]) begin
               swell_val_reg[p] <= rms_v[p];
            end
         end
      end
   end

   // no-load status follows the energy accumulators
   always_ff @(posedge I_CLK or negedge I_RESETN) begin
      if (!I_RESETN) begin
         noload_reg <= '0;
      end else begin
         noload_reg <= noload_now;
      end
   end

   // any-phase no-load for total active, reactive, apparent and fundamental active
   assign any_tot_act = noload_reg[0] | noload_reg[6] | noload_reg[12];
   assign any_tot_react = noload_reg[1] | noload_reg[7] | noload_reg[13];
   assign any_tot_app = noload_reg[2] | noload_reg[8] | noload_reg[14];
   assign any_fund_act = noload_reg[3] | noload_reg[9] | noload_reg[15];

   // enabled conditions that pull the event pin low
   assign evt_low =
      |(dip_act_reg & evt_en_reg[EN_DIP_LSB +: 3])
      | |(swell_act_reg & evt_en_reg[EN_SWELL_LSB +: 3])
      | (any_tot_act & evt_en_reg[EN_TOT_ACT])
      | (any_tot_react & evt_en_reg[EN_TOT_REACT])
      | (any_tot_app & evt_en_reg[EN_TOT_APP])
      | (any_fund_act & evt_en_reg[EN_FUND_ACT]);

   // registered active-low event pin
   always_ff @(posedge I_CLK or negedge I_RESETN) begin
      if (!I_RESETN) begin
         event_n_reg <= 1'b1;
      end else begin
         event_n_reg <= !evt_low;
      end
   end

   // interrupt events: entry into dip, swell or any no-load
   always_comb begin
      irq_set = '0;
      if (I_RMS.valid) begin
         irq_set[IRQ_DIP_LSB +: 3] = dip_hit & ~dip_act_reg;
         irq_set[IRQ_SWELL_LSB +: 3] = swell_hit & ~swell_act_reg;
      end
      irq_set[IRQ_NOLOAD] = |(noload_now & ~noload_reg);
   end

   // a read of the status register clears it
   assign irq_clr = (rd_req && addr_ok && addr_idx == IDX_IRQ_STAT) ?
                    irq_stat_reg : '0;

   // sticky status, a new event wins over the clear
   always_ff @(posedge I_CLK or negedge I_RESETN) begin
      if (!I_RESETN) begin
         irq_stat_reg <= RST_IRQ;
      end else begin
         irq_stat_reg <= (irq_stat_reg & ~irq_clr) | irq_set;
      end
   end

   // level interrupt while an unmasked status bit stands
   always_ff @(posedge I_CLK or negedge I_RESETN) begin
      if (!I_RESETN) begin
         irq_reg <= 1'b0;
      end else begin
         irq_reg <= |(((irq_stat_reg & ~irq_clr) | irq_set) & irq_mask_reg);
      end
   end

   // read mux, unmapped addresses read zero
   always_comb begin
      rd_val = 32'h00000000;
      if (addr_ok) begin
         unique case (addr_idx)
            IDX_DIP_THR: rd_val = fwd(word24(dip_thr_reg), I_HWDATA,
               32'h00FFFFFF, wr_pend_reg && dph_reg.idx == IDX_DIP_THR);
            IDX_DIP_A: rd_val = word24(dip_val_reg[0]);
            IDX_DIP_B: rd_val = word24(dip_val_reg[1]);
            IDX_DIP_C: rd_val = word24(dip_val_reg[2]);
            IDX_SWELL_THR: rd_val = fwd(word24(swell_thr_reg), I_HWDATA,
               32'h00FFFFFF, wr_pend_reg && dph_reg.idx == IDX_SWELL_THR);
            IDX_SWELL_A: rd_val = word24(swell_val_reg[0]);
            IDX_SWELL_B: rd_val = word24(swell_val_reg[1]);
            IDX_SWELL_C: rd_val = word24(swell_val_reg[2]);
            IDX_NOLOAD: rd_val = {14'h0000, noload_reg};
            IDX_EVT_EN: rd_val = fwd({18'h00000, evt_en_reg}, I_HWDATA,
               32'h00003FFF, wr_pend_reg && dph_reg.idx == IDX_EVT_EN);
            IDX_IRQ_STAT: rd_val = {25'h0000000, irq_stat_reg};
            IDX_IRQ_MASK: rd_val = fwd({25'h0000000, irq_mask_reg},
               I_HWDATA, 32'h0000007F,
               wr_pend_reg && dph_reg.idx == IDX_IRQ_MASK);
            default: rd_val = 32'h00000000;
         endcase
      end
   end

   // read data registered at the address phase
   always_ff @(posedge I_CLK or negedge I_RESETN) begin
      if (!I_RESETN) begin
         rdata_reg <= 32'h00000000;
      end else if (rd_req) begin
         rdata_reg <= rd_val;
      end
   end
endmodule
`default_nettype wire

// *** pq_event_regs_bench.sv ***
`timescale 1ns/1ns
`default_nettype none
module pq_event_regs_bench;
   import pq_event_pkg::*;
   logic clk, resetn, hsel, hwrite, readyout, hresp, event_n, irq;
   logic [1:0] htrans;
   logic [31:0] haddr, hwdata, hrdata, rd;
   rms_sample_t rms;
   noload_t noload, nl;
   int num_errors, cmp_count;
   // design under test, hready looped back from hreadyout
   pq_event_regs DUT (.I_CLK(clk), .I_RESETN(resetn), .I_HSEL(hsel),
      .I_HADDR(haddr), .I_HTRANS(htrans), .I_HWRITE(hwrite),
      .I_HSIZE(3'h2), .I_HWDATA(hwdata), .I_HREADY(readyout),
      .O_HRDATA(hrdata), .O_HREADYOUT(readyout), .O_HRESP(hresp),
      .I_RMS(rms), .I_NOLOAD(noload), .O_EVENT_N(event_n), .O_IRQ(irq));
   // 100 ns clock
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   task automatic complete_run;
      $display("compares %0d mismatches %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         num_errors++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // bounded wait for hready sampled high at a rising edge
   task automatic wait_rdy;
      int n;
      n = 0;
      @(posedge clk);
      while (readyout !== 1'b1) begin
         n++;
         if (n > 20) begin
            num_errors++;
            complete_run();
         end
         @(posedge clk);
      end
   endtask
   // one single ahb transfer; read data lands in rd
   task automatic bus(input logic w, input logic [31:0] a,
                      input logic [31:0] wd);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'h2;
      hwrite <= w;
      wait_rdy();
      htrans <= 2'h0;
      hwdata <= wd;
      wait_rdy();
      rd = hrdata;
      // every transfer must end with an okay response
      check({31'h0, hresp}, 32'h0);
   endtask
   function automatic logic [31:0] ra(input logic [11:0] i);
      return {18'h0, i, 2'b00};
   endfunction
   task automatic wr(input logic [11:0] i, input logic [31:0] d);
      bus(1'b1, ra(i), d);
   endtask
   task automatic rdchk(input logic [11:0] i, input logic [31:0] exp);
      bus(1'b0, ra(i), 32'h0);
      check(rd, exp);
   endtask
   task automatic pulse(input logic [23:0] va, vb, vc);
      rms <= '{1'b1, va, vb, vc};
      @(posedge clk);
      rms.valid <= 1'b0;
      @(posedge clk);
   endtask
   task automatic wt(input int n);
      repeat (n) @(posedge clk);
   endtask
   initial begin
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hwdata = 32'h0;
      rms = '0;
      noload = '0;
      nl = '0;
      resetn = 1'b0;
      num_errors = 0;
      cmp_count = 0;
      repeat (8) @(posedge clk);
      resetn <= 1'b1;
      @(posedge clk);
      rdchk(IDX_DIP_THR, 32'h0);
      rdchk(IDX_SWELL_THR, 32'h00FFFFFF);
      for (int p = 0; p < 3; p++) begin
         rdchk(IDX_DIP_A + 12'(p), 32'h007FFFFF);
         rdchk(IDX_SWELL_A + 12'(p), 32'h0);
      end
      rdchk(IDX_NOLOAD, 32'h0);
      // reset thresholds keep both detectors off
      pulse(24'h000000, 24'hFFFFFF, 24'h000000);
      rdchk(IDX_DIP_A, 32'h007FFFFF);
      rdchk(IDX_SWELL_B, 32'h0);
      $display("test reset values done");
      wr(IDX_DIP_THR, 32'hAB100000);
      rdchk(IDX_DIP_THR, 32'h00100000);
      wr(IDX_SWELL_THR, 32'hFF200000);
      rdchk(IDX_SWELL_THR, 32'h00200000);
      wr(IDX_DIP_A, 32'h00000123);
      rdchk(IDX_DIP_A, 32'h007FFFFF);
      $display("test thresholds done");
      // values equal to a threshold must not capture
      pulse(24'h0FFFFF, 24'h100000, 24'h200001);
      rdchk(IDX_DIP_A, 32'h000FFFFF);
      rdchk(IDX_DIP_B, 32'h007FFFFF);
      rdchk(IDX_SWELL_C, 32'h00200001);
      pulse(24'h200000, 24'h0FFFF0, 24'h150000);
      rdchk(IDX_DIP_A, 32'h000FFFFF);
      rdchk(IDX_DIP_B, 32'h000FFFF0);
      rdchk(IDX_SWELL_A, 32'h0);
      rdchk(IDX_SWELL_C, 32'h00200001);
      $display("test capture done");
      check({31'h0, event_n}, 32'h1);
      wr(IDX_EVT_EN, 32'h2);
      wt(3);
      check({31'h0, event_n}, 32'h0);
      wr(IDX_EVT_EN, 32'h1);
      wt(3);
      check({31'h0, event_n}, 32'h1);
      wr(IDX_EVT_EN, 32'h8);
      pulse(24'h200001, 24'h150000, 24'h150000);
      wt(2);
      check({31'h0, event_n}, 32'h0);
      $display("test dip swell event done");
      for (int k = 0; k < 18; k++) begin
         noload <= noload_t'(18'h1 << k);
         wt(2);
         rdchk(IDX_NOLOAD, 32'h1 << k);
      end
      $display("test no-load status done");
      for (int j = 0; j < 4; j++) begin
         wr(IDX_EVT_EN, 32'h400 << j);
         noload <= noload_t'(18'h40 << j);
         wt(3);
         check({31'h0, event_n}, 32'h0);
         noload <= noload_t'(18'h40 << ((j + 1) % 4));
         wt(3);
         check({31'h0, event_n}, 32'h1);
      end
      wr(IDX_EVT_EN, 32'h800);
      // drive phase c total reactive by name, expect bit 13
      nl = '0;
      nl.pc.total_reactive = 1'b1;
      noload <= nl;
      wt(3);
      check({31'h0, event_n}, 32'h0);
      rdchk(IDX_NOLOAD, 32'h00002000);
      $display("test no-load event done");
      // interrupt: masked, unmasked, cleared by reading status
      wr(IDX_EVT_EN, 32'h0);
      noload <= '0;
      wt(2);
      bus(1'b0, ra(IDX_IRQ_STAT), 32'h0);
      noload <= noload_t'(18'h1);
      wt(3);
      check({31'h0, irq}, 32'h0);
      wr(IDX_IRQ_MASK, 32'h40);
      wt(2);
      check({31'h0, irq}, 32'h1);
      rdchk(IDX_IRQ_STAT, 32'h40);
      wt(2);
      check({31'h0, irq}, 32'h0);
      rdchk(IDX_IRQ_STAT, 32'h0);
      $display("test interrupt done");
      bus(1'b0, 32'h00010000 | ra(IDX_DIP_THR), 32'h0);
      check(rd, 32'h0);
      bus(1'b1, 32'h00010000 | ra(IDX_DIP_THR), 32'h5);
      rdchk(IDX_DIP_THR, 32'h00100000);
      rdchk(12'h418, 32'h0);
      $display("test unmapped done");
      complete_run();
   end
endmodule
`default_nettype wire

// *** pq_event_regs_sva.sv ***
`timescale 1ns/1ns
`default_nettype none
module pq_event_regs_chk
   import pq_event_pkg::*;
(
   // clock and reset
   input wire logic I_CLK,
   input wire logic I_RESETN,
   // bus signals
   input wire logic I_HSEL,
   input wire logic [31:0] I_HADDR,
   input wire logic [1:0] I_HTRANS,
   input wire logic I_HWRITE,
   input wire logic [31:0] I_HWDATA,
   input wire logic I_HREADY,
   input wire logic [31:0] O_HRDATA,
   input wire logic O_HREADYOUT,
   input wire logic O_HRESP,
   // metering
   input wire pq_event_pkg::noload_t I_NOLOAD
);
   logic take, rd, wr, mapped;
   logic [11:0] idx;
   default clocking @(posedge I_CLK); endclocking
   default disable iff (!I_RESETN);
   // decode of the address phase taken at this edge
   assign take = I_HSEL && I_HREADY && I_HTRANS[1];
   assign rd = take && !I_HWRITE;
   assign wr = take && I_HWRITE;
   assign idx = I_HADDR[13:2];
   assign mapped = (I_HADDR[31:14] == 18'h0) && (I_HADDR[1:0] == 2'h0);
   AST_NL_A: assert property ((rd && mapped && idx == IDX_NOLOAD &&
      $past(I_RESETN) && I_NOLOAD == $past(I_NOLOAD)) |=>
      O_HRDATA[5:0] == $past(I_NOLOAD[5:0])) else $error("phase a no-load");
   AST_NL_B: assert property ((rd && mapped && idx == IDX_NOLOAD &&
      $past(I_RESETN) && I_NOLOAD == $past(I_NOLOAD)) |=>
      O_HRDATA[11:6] == $past(I_NOLOAD[11:6])) else $error("phase b no-load");
   AST_NL_C: assert property ((rd && mapped &&
      idx == IDX_NOLOAD && $past(I_RESETN) &&
      I_NOLOAD == $past(I_NOLOAD)) |=>
      O_HRDATA[31:12] == {14'h0, $past(I_NOLOAD[17:12])})
      else $error("phase c no-load or upper bits");
   AST_RSV: assert property ((rd && mapped &&
      idx >= IDX_DIP_THR && idx <= IDX_SWELL_C) |=> O_HRDATA[31:24] == 8'h00)
      else $error("reserved bits not zero");
   AST_DIP_FWD: assert property ((wr && mapped && idx == IDX_DIP_THR)
      ##1 !take ##1 (rd && mapped && idx == IDX_DIP_THR) |=>
      O_HRDATA == {8'h00, $past(I_HWDATA[23:0], 2)})
      else $error("dip threshold readback");
   AST_SWL_FWD: assert property ((wr && mapped &&
      idx == IDX_SWELL_THR) ##1 !take ##1
      (rd && mapped && idx == IDX_SWELL_THR) |=>
      O_HRDATA == {8'h00, $past(I_HWDATA[23:0], 2)})
      else $error("swell threshold readback");
   AST_UNMAP: assert property ((rd && !mapped) |=> O_HRDATA == 32'h0)
      else $error("unmapped read not zero");
   AST_READY: assert property (O_HREADYOUT == 1'b1) else $error("wait state");
   AST_OKAY: assert property (O_HRESP == 1'b0) else $error("error response");
endmodule
bind pq_event_regs pq_event_regs_chk u_chk (.I_CLK(I_CLK),
   .I_RESETN(I_RESETN), .I_HSEL(I_HSEL), .I_HADDR(I_HADDR),
   .I_HTRANS(I_HTRANS), .I_HWRITE(I_HWRITE), .I_HWDATA(I_HWDATA),
   .I_HREADY(I_HREADY), .O_HRDATA(O_HRDATA), .O_HREADYOUT(O_HREADYOUT),
   .O_HRESP(O_HRESP), .I_NOLOAD(I_NOLOAD));
`default_nettype wire
